// >>> hw/sac_top.sv
`timescale 1ns/10ps
// Functional notes
// - Eight-bit result by successive approximation
// - Each conversion lasts 36 system cycles
// - Eighth shift falling edge starts conversion
// - Convert address stored when conversion starts
// - MSB driven after three settle cycles once synchronised select is low
// - Bits six to zero on falling edges
// - Ignore shift clock and address while select is high
// - Choose eleven inputs or self-test voltage
// - Sample-hold automatic or host timed
// - Three-state output, four control inputs
// - Result out and address in together
module sac_top
  import sac_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 io_clk,
  input  wire logic                 cs_n,
  input  wire logic                 addr_in,
  input  wire logic                 cmp_in,
  input  wire logic                 sh_host_mode,
  input  wire logic                 sh_host_hold,
  output logic                      data_out_q,
  output logic                      data_oe_q,
  output logic [sac_pkg::RES_BITS-1:0] dac_code,
  output logic [3:0]                mux_sel_q,
  output logic                      self_test_q,
  output logic                      sh_hold_q,
  output logic                      conv_busy
);

  import sac_pkg::*;

  localparam int          IDX_W   = $clog2(RES_BITS);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(RES_BITS - 1);

  // ----------------------------------------------------------------
  // Link domain on the shift clock
  // ----------------------------------------------------------------
  // Select high holds the frame counters cleared
  logic                 io_rst_n;
  logic [2:0]           rise_cnt_q;
  logic [2:0]           rise_cnt_d;
  logic [ADDR_BITS-1:0] addr_sh_q;
  logic [ADDR_BITS-1:0] addr_sh_d;
  logic [3:0]           fall_cnt_q;
  logic [3:0]           fall_cnt_d;
  logic                 fall_tgl_q;
  logic                 fall_tgl_d;
  logic                 start_tgl_q;
  logic                 start_tgl_d;

  assign io_rst_n = nrst & ~cs_n;

  always_comb begin
    rise_cnt_d = rise_cnt_q;
    addr_sh_d  = addr_sh_q;
    if (int'(rise_cnt_q) < ADDR_EDGES) begin
      rise_cnt_d = rise_cnt_q + 3'h1;
      addr_sh_d  = {addr_sh_q[ADDR_BITS-2:0], addr_in};
    end
  end

  always_ff @(posedge io_clk or negedge io_rst_n) begin
    if (!io_rst_n) begin
      rise_cnt_q <= 3'h0;
    end else begin
      rise_cnt_q <= rise_cnt_d;
    end
  end

  // Stored address survives select going high
  always_ff @(posedge io_clk or negedge nrst) begin
    if (!nrst) begin
      addr_sh_q <= ADDR_RST;
    end else if (!cs_n) begin
      addr_sh_q <= addr_sh_d;
    end
  end

  always_comb begin
    fall_cnt_d  = fall_cnt_q;
    fall_tgl_d  = fall_tgl_q;
    start_tgl_d = start_tgl_q;
    if (!cs_n) begin
      fall_tgl_d = ~fall_tgl_q;
      if (int'(fall_cnt_q) < START_FALL) begin
        fall_cnt_d = fall_cnt_q + 4'h1;
      end
      if (int'(fall_cnt_q) == START_FALL - 1) begin
        start_tgl_d = ~start_tgl_q;
      end
    end
  end

  always_ff @(negedge io_clk or negedge io_rst_n) begin
    if (!io_rst_n) begin
      fall_cnt_q <= 4'h0;
    end else begin
      fall_cnt_q <= fall_cnt_d;
    end
  end

  always_ff @(negedge io_clk or negedge nrst) begin
    if (!nrst) begin
      fall_tgl_q  <= 1'b0;
      start_tgl_q <= 1'b0;
    end else begin
      fall_tgl_q  <= fall_tgl_d;
      start_tgl_q <= start_tgl_d;
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the system clock
  // ----------------------------------------------------------------
  logic [4:0] sync_in;
  logic [4:0] sync_out;
  logic       cs_s;
  logic       fall_s;
  logic       start_s;
  logic       hhold_s;
  logic       hmode_s;

  // Select enters inverted so that the synchroniser resets to the idle level
  assign sync_in = {sh_host_mode, sh_host_hold, start_tgl_q, fall_tgl_q, ~cs_n};
  assign cs_s    = ~sync_out[0];
  assign fall_s  = sync_out[1];
  assign start_s = sync_out[2];
  assign hhold_s = sync_out[3];
  assign hmode_s = sync_out[4];

  sac_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk      (sys_clk),
    .rst_n    (nrst),
    .async_in (sync_in),
    .sync_out (sync_out)
  );

  logic cs_prev_q;
  logic fall_prev_q;
  logic start_prev_q;
  logic cs_fall;
  logic fall_edge;
  logic start_edge;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cs_prev_q    <= 1'b1;
      fall_prev_q  <= 1'b0;
      start_prev_q <= 1'b0;
    end else begin
      cs_prev_q    <= cs_s;
      fall_prev_q  <= fall_s;
      start_prev_q <= start_s;
    end
  end

  assign cs_fall    = cs_prev_q & ~cs_s;
  assign fall_edge  = fall_prev_q ^ fall_s;
  assign start_edge = start_prev_q ^ start_s;

  // ----------------------------------------------------------------
  // Conversion control and channel multiplexer
  // ----------------------------------------------------------------
  logic                sar_busy;
  logic                sar_done;
  logic [RES_BITS-1:0] sar_result;
  logic                sar_go;
  logic [RES_BITS-1:0] result_q;
  logic [RES_BITS-1:0] result_d;
  logic [3:0]          mux_sel_d;
  logic                self_test_d;
  logic                sh_hold_d;

  // A start that lands on a running conversion is dropped
  assign sar_go = start_edge & ~sar_busy;

  sac_sar #(
    .NBITS (RES_BITS),
    .NCYC  (CONV_CYCLES)
  ) u_sar (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .start    (sar_go),
    .cmp_in   (cmp_in),
    .busy_q   (sar_busy),
    .done_q   (sar_done),
    .trial_q  (dac_code),
    .result_q (sar_result)
  );

  assign conv_busy = sar_busy;

  always_comb begin
    mux_sel_d   = mux_sel_q;
    self_test_d = self_test_q;
    result_d    = result_q;
    // The stored address is stable from the fourth rising edge on
    if (sar_go) begin
      if (int'(addr_sh_q) < NUM_EXT_CH) begin
        mux_sel_d   = addr_sh_q;
        self_test_d = 1'b0;
      end else begin
        mux_sel_d   = SELF_TEST_CH;
        self_test_d = 1'b1;
      end
    end
    if (sar_done) begin
      result_d = sar_result;
    end
    sh_hold_d = hmode_s ? hhold_s : sar_busy;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mux_sel_q   <= 4'h0;
      self_test_q <= 1'b0;
      result_q    <= RESULT_RST;
      sh_hold_q   <= 1'b0;
    end else begin
      mux_sel_q   <= mux_sel_d;
      self_test_q <= self_test_d;
      result_q    <= result_d;
      sh_hold_q   <= sh_hold_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial result output
  // ----------------------------------------------------------------
  sac_link_e        state_q;
  sac_link_e        state_d;
  logic [1:0]       settle_q;
  logic [1:0]       settle_d;
  logic [IDX_W-1:0] bit_idx_q;
  logic [IDX_W-1:0] bit_idx_d;
  logic             data_out_d;
  logic             data_oe_d;

  always_comb begin
    state_d    = state_q;
    settle_d   = settle_q;
    bit_idx_d  = bit_idx_q;
    data_oe_d  = data_oe_q;
    data_out_d = data_out_q;
    case (state_q)
      LNK_IDLE: begin
        data_oe_d = 1'b0;
        if (cs_fall) begin
          state_d  = LNK_SETTLE;
          settle_d = 2'h0;
        end
      end
      LNK_SETTLE: begin
        settle_d = settle_q + 2'h1;
        if (int'(settle_q) == CS_SETTLE_CYCLES - 1) begin
          state_d    = LNK_SHIFT;
          bit_idx_d  = '0;
          data_oe_d  = 1'b1;
          data_out_d = result_q[RES_BITS-1];
        end
      end
      LNK_SHIFT: begin
        if (fall_edge && bit_idx_q != IDX_LAST) begin
          bit_idx_d = bit_idx_q + 1'b1;
        end
        data_out_d = result_q[IDX_LAST - bit_idx_d];
      end
      default: begin
        state_d = LNK_IDLE;
      end
    endcase
    if (cs_s) begin
      state_d   = LNK_IDLE;
      bit_idx_d = '0;
      data_oe_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= LNK_IDLE;
      settle_q   <= 2'h0;
      bit_idx_q  <= '0;
      data_oe_q  <= 1'b0;
      data_out_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      settle_q   <= settle_d;
      bit_idx_q  <= bit_idx_d;
      data_oe_q  <= data_oe_d;
      data_out_q <= data_out_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_settle;
    ##1 !data_oe_q [*3];
  endsequence

  sequence s_drive_msb;
    ##1 (data_oe_q && data_out_q == result_q[RES_BITS-1]);
  endsequence

  a_settle_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_q == LNK_IDLE && cs_fall) |-> s_settle ##0 (1'b1 ##1 (data_oe_q || cs_s || $past(cs_s))))
    else $error("output did not follow the select settle time");

  a_msb_first: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_q == LNK_SETTLE && int'(settle_q) == CS_SETTLE_CYCLES - 1 && !cs_s) |-> s_drive_msb)
    else $error("MSB not driven after select low");

  a_hiz_select: assert property (@(posedge sys_clk) disable iff (!nrst)
    cs_s |=> (!data_oe_q && bit_idx_q == '0 && state_q == LNK_IDLE))
    else $error("output driven or counter kept with select high");

  a_shift_step: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_q == LNK_SHIFT && fall_edge && bit_idx_q != IDX_LAST && !cs_s)
      |=> (bit_idx_q == $past(bit_idx_q) + 1'b1 && data_out_q == result_q[IDX_LAST - bit_idx_q]))
    else $error("result bit not advanced on shift falling edge");

  a_start_conv: assert property (@(posedge sys_clk) disable iff (!nrst)
    sar_go |=> sar_busy)
    else $error("conversion not started by eighth falling edge");

  a_addr_used: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sar_go && int'(addr_sh_q) < NUM_EXT_CH) |=> (mux_sel_q == $past(addr_sh_q) && !self_test_q))
    else $error("converted channel differs from stored address");

  a_self_test: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sar_go && int'(addr_sh_q) >= NUM_EXT_CH) |=> (mux_sel_q == SELF_TEST_CH && self_test_q))
    else $error("self-test voltage not selected");

  a_hold_auto: assert property (@(posedge sys_clk) disable iff (!nrst)
    !hmode_s |=> sh_hold_q == $past(sar_busy))
    else $error("automatic hold does not track the conversion");

  a_result_load: assert property (@(posedge sys_clk) disable iff (!nrst)
    sar_done |=> result_q == $past(sar_result))
    else $error("result register not loaded at conversion end");

endmodule

// >>> hw/sac_pkg.sv
package sac_pkg;

  // ----------------------------------------------------------------
  // Converter sizes and channel map
  // ----------------------------------------------------------------
  localparam int          RES_BITS         = 8;
  localparam int          ADDR_BITS        = 4;
  localparam int          NUM_EXT_CH       = 11;
  localparam logic [3:0]  SELF_TEST_CH     = 4'hb;

  // ----------------------------------------------------------------
  // Cycle counts on the system clock
  // ----------------------------------------------------------------
  localparam int          CONV_CYCLES      = 36;
  localparam int          SAR_STEP         = 4;
  localparam int          CS_SETTLE_CYCLES = 3;

  // ----------------------------------------------------------------
  // Link edge counts on the shift clock
  // ----------------------------------------------------------------
  localparam int          ADDR_EDGES       = 4;
  localparam int          START_FALL       = 8;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  RESULT_RST       = 8'h00;
  localparam logic [3:0]  ADDR_RST         = 4'h0;

  typedef enum logic [1:0] {
    LNK_IDLE,
    LNK_SETTLE,
    LNK_SHIFT
  } sac_link_e;

endpackage

// >>> hw/sac_sync.sv
`timescale 1ns/10ps
module sac_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_d;

  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : sync_out[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      sync_out <= '0;
    end else begin
      s1_q     <= async_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      sync_out <= out_d;
    end
  end

endmodule

// >>> hw/sac_sar.sv
`timescale 1ns/10ps
module sac_sar
  import sac_pkg::*;
#(
  parameter int NBITS  = sac_pkg::RES_BITS,
  parameter int NCYC   = sac_pkg::CONV_CYCLES
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             start,
  input  wire logic             cmp_in,
  output logic                  busy_q,
  output logic                  done_q,
  output logic      [NBITS-1:0] trial_q,
  output logic      [NBITS-1:0] result_q
);

  localparam int CW = $clog2(NCYC);

  if (NCYC != SAR_STEP * (NBITS + 1)) begin : g_bad_cfg
    $error("sac_sar: cycle count does not fit the bit count");
  end

  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic             busy_d;
  logic             done_d;
  logic [NBITS-1:0] trial_d;
  logic [NBITS-1:0] result_d;
  int               bitpos;

  // ----------------------------------------------------------------
  // Sample for one step, then one decision per step, MSB first
  // ----------------------------------------------------------------
  always_comb begin
    bitpos   = 0;
    count_d  = count_q;
    busy_d   = busy_q;
    done_d   = 1'b0;
    trial_d  = trial_q;
    result_d = result_q;
    if (!busy_q) begin
      if (start) begin
        busy_d  = 1'b1;
        count_d = '0;
        trial_d = {1'b1, {(NBITS-1){1'b0}}};
      end
    end else begin
      count_d = count_q + 1'b1;
      if (int'(count_q) >= SAR_STEP && (int'(count_q) % SAR_STEP) == SAR_STEP - 1) begin
        bitpos = NBITS - (int'(count_q) / SAR_STEP);
        if (!cmp_in) begin
          trial_d[bitpos] = 1'b0;
        end
        if (bitpos > 0) begin
          trial_d[bitpos-1] = 1'b1;
        end
      end
      if (int'(count_q) == NCYC - 1) begin
        busy_d   = 1'b0;
        done_d   = 1'b1;
        result_d = trial_d;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count_q  <= '0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      trial_q  <= '0;
      result_q <= '0;
    end else begin
      count_q  <= count_d;
      busy_q   <= busy_d;
      done_q   <= done_d;
      trial_q  <= trial_d;
      result_q <= result_d;
    end
  end

  a_conv_length: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(busy_q) |-> ##35 busy_q ##1 (!busy_q && done_q))
    else $error("conversion did not take 36 cycles");

  a_trial_msb: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(busy_q) |-> trial_q == {1'b1, {(NBITS-1){1'b0}}})
    else $error("conversion did not start from the midscale trial");

endmodule

// >>> test/sac_host.sv
`timescale 1ns/10ps
module sac_host (
  input  wire logic       sys_clk,
  input  wire logic       data_out_q,
  input  wire logic       data_oe_q,
  output logic            io_clk,
  output logic            cs_n,
  output logic            addr_in,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic [7:0]      rx_oe
);
  // ----------------------------------------------------------------
  // Idle levels: shift clock stands still low between frames
  // ----------------------------------------------------------------
  initial begin
    io_clk   = 1'b0;
    cs_n     = 1'b1;
    addr_in  = 1'b0;
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    rx_oe    = 8'h00;
  end

  // ----------------------------------------------------------------
  // One transfer: nfall falling edges, result in, address out
  // ----------------------------------------------------------------
  task automatic frame(input logic [3:0] addr, input int nfall, input logic keep_low);
    logic [7:0] sh;
    logic [7:0] oe;
    sh = 8'h00;
    oe = 8'h00;
    @(posedge sys_clk);
    #1 cs_n = 1'b0;
    repeat (12) @(posedge sys_clk);
    #7.3;
    for (int k = 0; k < nfall; k++) begin
      // Address bit set half a period before the rising edge
      addr_in = (k < 4) ? addr[3-k] : ~addr_in;
      #24 io_clk = 1'b1;
      #23.95;
      if (k < 8) begin
        // Undriven line shows the inverse of the last driven value
        sh[7-k] = data_oe_q ? data_out_q : ~data_out_q;
        oe[7-k] = data_oe_q;
      end
      #0.05 io_clk = 1'b0;
    end
    if (nfall == 8) begin
      rx_byte  = sh;
      rx_oe    = oe;
      rx_valid = 1'b1;
      #1 rx_valid = 1'b0;
    end
    if (keep_low) begin
      repeat (50) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    #1 cs_n = 1'b1;
    // Released line shows the inverse of its last value
    addr_in = ~addr_in;
    repeat (50) @(posedge sys_clk);
  endtask
endmodule

// >>> test/sac_top_tb.sv
`timescale 1ns/10ps
module sac_top_tb;
  import sac_pkg::*;

  logic        sys_clk;
  logic        nrst;
  logic        io_clk;
  logic        cs_n;
  logic        addr_in;
  logic        cmp_in;
  logic        sh_host_mode;
  logic        sh_host_hold;
  logic        data_out_q;
  logic        data_oe_q;
  logic [7:0]  dac_code;
  logic [3:0]  mux_sel_q;
  logic        self_test_q;
  logic        sh_hold_q;
  logic        conv_busy;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic [7:0]  rx_oe;
  logic [7:0]  ch_val [16];
  logic [7:0]  exp_q [$];
  int          num_errors = 0;
  int          n_tests = 0;
  int          busy_cnt = 0;
  logic        busy_prev = 1'b0;
  logic        auto_chk = 1'b1;

  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Analog source: comparator against the selected channel
  // ----------------------------------------------------------------
  assign cmp_in = (ch_val[mux_sel_q] >= dac_code);

  sac_top dut_u (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .io_clk       (io_clk),
    .cs_n         (cs_n),
    .addr_in      (addr_in),
    .cmp_in       (cmp_in),
    .sh_host_mode (sh_host_mode),
    .sh_host_hold (sh_host_hold),
    .data_out_q   (data_out_q),
    .data_oe_q    (data_oe_q),
    .dac_code     (dac_code),
    .mux_sel_q    (mux_sel_q),
    .self_test_q  (self_test_q),
    .sh_hold_q    (sh_hold_q),
    .conv_busy    (conv_busy)
  );

  sac_host host_u (
    .sys_clk    (sys_clk),
    .data_out_q (data_out_q),
    .data_oe_q  (data_oe_q),
    .io_clk     (io_clk),
    .cs_n       (cs_n),
    .addr_in    (addr_in),
    .rx_valid   (rx_valid),
    .rx_byte    (rx_byte),
    .rx_oe      (rx_oe)
  );

  // ----------------------------------------------------------------
  // Compare and verdict
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] expv, input string what);
    n_tests++;
    if (seen !== expv) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d, comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Monitors: serial result, busy span, automatic hold
  // ----------------------------------------------------------------
  always @(posedge rx_valid) begin
    if (exp_q.size() == 0) begin
      check(rx_byte, 8'hxx, "unexpected result");
    end else begin
      check(rx_byte, exp_q.pop_front(), "serial result");
    end
    check(rx_oe, 8'hff, "output enable while shifting");
  end

  always @(negedge sys_clk) begin
    if (conv_busy === 1'b1) begin
      busy_cnt++;
    end else if (busy_cnt != 0) begin
      check(8'(busy_cnt), 8'(CONV_CYCLES), "busy span");
      busy_cnt = 0;
    end
    if (auto_chk && nrst) begin
      check(8'(sh_hold_q), 8'(busy_prev), "automatic hold");
    end
    busy_prev = conv_busy;
  end

  initial begin
    #100000;
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] a;
    logic [3:0] sel;
    logic [7:0] prev;
    nrst         = 1'b0;
    sh_host_mode = 1'b0;
    sh_host_hold = 1'b0;
    void'($urandom(32'h4aa1));
    for (int i = 0; i < 16; i++) begin
      ch_val[i] = 8'($urandom_range(255, 0));
    end
    repeat (5) @(posedge sys_clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check(8'(data_oe_q), 8'h00, "oe after reset");
    check(8'(mux_sel_q), 8'(ADDR_RST), "channel after reset");
    prev = RESULT_RST;
    for (int i = 0; i < 24; i++) begin
      a = (i < 16) ? 4'(i) : 4'($urandom_range(15, 0));
      exp_q.push_back(prev);
      host_u.frame(a, 8, i[0]);
      #1;
      sel = (a > 4'ha) ? SELF_TEST_CH : a;
      check(8'(mux_sel_q), 8'(sel), "channel select");
      check(8'(self_test_q), 8'(a > 4'ha), "self-test select");
      check(8'(data_oe_q), 8'h00, "oe with select high");
      prev = ch_val[sel];
      ch_val[sel] = 8'($urandom_range(255, 0));
      if (i == 10 || i == 17) begin
        // Aborted transfer: no eighth falling edge, no conversion
        host_u.frame(a ^ 4'h5, 6, 1'b0);
        #1;
        check(8'(mux_sel_q), 8'(sel), "no start before eighth edge");
      end
    end
    auto_chk     = 1'b0;
    sh_host_mode = 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      #1 sh_host_hold = 1'($urandom_range(1, 0));
      repeat (10) @(posedge sys_clk);
      #1;
      check(8'(sh_hold_q), 8'(sh_host_hold), "host-timed hold");
    end
    check(8'(exp_q.size()), 8'h00, "results outstanding");
    end_sim();
  end
endmodule
